// ---- core/cdba_unit.sv ----
// Execution unit for compare, decrement, decrement-skip and BCD adjust
//
// How it works
// - Compare: file minus working sets zero and carry; nothing stored.
// - Decrement writes file value minus one to working or file, zero only.
// - Decrement-skip routes file value minus one by destination bit.
// - BCD adjust rewrites working register as packed decimal, carry only.
`timescale 1ns/1ps
module cdba_unit (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                issue_valid,
   input  wire cdba_pkg::cdba_req_t issue,
   output cdba_pkg::cdba_wb_t       wb_q,
   output logic                     squash_q,
   output logic                     nop_q
);

   cdba_pkg::cdba_state_t state_q;
   cdba_pkg::cdba_state_t state_d;
   cdba_pkg::cdba_wb_t    wb_d;

   wire logic                        take;
   wire logic                        discard;
   wire logic                        is_cmp;
   wire logic                        is_dec;
   wire logic                        is_dsz;
   wire logic                        is_bcd;
   wire logic                        any_dec;
   wire logic [cdba_pkg::DATA_W:0]   cmp_diff;
   wire logic [cdba_pkg::DATA_W-1:0] dec_val;
   wire logic                        dec_zero;
   wire logic                        to_file;
   wire logic [cdba_pkg::DATA_W-1:0] bcd_val;
   wire logic                        bcd_carry;
   wire logic                        skip_now;

   // Two nibbles and a single squash state are all the logic can serve
   if (cdba_pkg::DATA_W != 8) begin : g_data_w_check
      $error("cdba_unit: datapath must be two nibbles wide");
   end
   if (cdba_pkg::SKIP_CYCLES != 2) begin : g_skip_check
      $error("cdba_unit: a skip must last exactly two cycles");
   end
   if (cdba_pkg::ADDR_W < 1) begin : g_addr_w_check
      $error("cdba_unit: file address needs at least one bit");
   end

   // In skip state the next issue is the prefetched one and is dropped
   assign discard = issue_valid & (state_q == cdba_pkg::CDBA_ST_SKIP);
   assign take    = issue_valid & (state_q == cdba_pkg::CDBA_ST_RUN);

   assign is_cmp  = take & (issue.op == cdba_pkg::CDBA_OP_COMPARE);
   assign is_dec  = take & (issue.op == cdba_pkg::CDBA_OP_DEC);
   assign is_dsz  = take & (issue.op == cdba_pkg::CDBA_OP_DEC_SKIP);
   assign is_bcd  = take & (issue.op == cdba_pkg::CDBA_OP_BCD_ADJUST);
   assign any_dec = is_dec | is_dsz;

   // Extra top bit is the inverted borrow, i.e. carry set when no borrow
   assign cmp_diff = {1'b0, issue.file_val}
                     + {1'b0, ~issue.working_val}
                     + {{cdba_pkg::DATA_W{1'b0}}, 1'b1};

   assign dec_val  = issue.file_val - 8'h01;
   assign dec_zero = (dec_val == cdba_pkg::DATA_RST);
   assign to_file  = (issue.dest == cdba_pkg::DEST_FILE);
   assign skip_now = is_dsz & dec_zero;

   // The adjust trusts the flags of the addition just before it
   cdba_bcd_adjust u_bcd (
      .bin_val       (issue.working_val),
      .carry_in      (issue.carry_in),
      .half_carry_in (issue.half_carry_in),
      .bcd_val       (bcd_val),
      .carry_out     (bcd_carry)
   );

   // Write-back fields picked per op; taken ops are mutually exclusive
   wire logic                        cmp_zero;
   wire logic                        cmp_carry;
   wire logic                        wb_working_we;
   wire logic [cdba_pkg::DATA_W-1:0] wb_working_data;
   wire logic                        wb_file_we;
   wire logic [cdba_pkg::DATA_W-1:0] wb_file_data;
   wire logic                        wb_zero_we;
   wire logic                        wb_zero_val;
   wire logic                        wb_carry_we;
   wire logic                        wb_carry_val;

   assign cmp_zero  = (cmp_diff[cdba_pkg::DATA_W-1:0]
                       == cdba_pkg::DATA_RST);
   assign cmp_carry = cmp_diff[cdba_pkg::DATA_W];

   // Compare writes neither operand back
   assign wb_working_we   = (any_dec & ~to_file)
                            | is_bcd;
   assign wb_working_data = is_bcd  ? bcd_val
                          : any_dec ? dec_val
                          : cdba_pkg::DATA_RST;
   assign wb_file_we      = any_dec & to_file;
   assign wb_file_data    = any_dec ? dec_val : cdba_pkg::DATA_RST;

   // Adjust leaves zero alone, decrement leaves carry alone
   assign wb_zero_we      = is_cmp | any_dec;
   assign wb_zero_val     = is_cmp  ? cmp_zero
                          : any_dec ? dec_zero
                          : 1'b0;
   assign wb_carry_we     = is_cmp | is_bcd;
   assign wb_carry_val    = is_cmp ? cmp_carry
                          : is_bcd ? bcd_carry
                          : 1'b0;

   // Address follows the issue even when nothing is written
   assign wb_d = '{
      working_we:   wb_working_we,
      working_data: wb_working_data,
      file_we:      wb_file_we,
      file_addr:    issue.file_addr,
      file_data:    wb_file_data,
      zero_we:      wb_zero_we,
      zero_val:     wb_zero_val,
      carry_we:     wb_carry_we,
      carry_val:    wb_carry_val
   };

   always_comb begin
      state_d = state_q;
      case (state_q)
         cdba_pkg::CDBA_ST_RUN: begin
            if (skip_now) begin
               state_d = cdba_pkg::CDBA_ST_SKIP;
            end
         end
         cdba_pkg::CDBA_ST_SKIP: begin
            // Waits for the prefetched instruction, then back to run
            if (issue_valid) begin
               state_d = cdba_pkg::CDBA_ST_RUN;
            end
         end
         default: begin
            state_d = cdba_pkg::CDBA_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= cdba_pkg::CDBA_ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_q <= cdba_pkg::WB_RST;
      end else begin
         wb_q <= wb_d;
      end
   end

   // One pulse per decrement-skip zero result, so the core squashes exactly one fetch
   always_ff @(posedge clk) begin
      if (rst) begin
         squash_q <= 1'b0;
      end else begin
         squash_q <= skip_now;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         nop_q <= 1'b0;
      end else begin
         nop_q <= discard;
      end
   end

endmodule // cdba_unit

// ---- core/cdba_pkg.sv ----
// Shared types and constants for the compare, decrement and BCD adjust unit
package cdba_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 6;

   // Nibble limit and correction values for BCD adjustment
   localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;
   localparam logic [3:0] BCD_NIBBLE_FIX = 4'h6;

   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;

   // Destination bit encoding
   localparam logic DEST_WORKING = 1'b0;
   localparam logic DEST_FILE    = 1'b1;

   // Cycles taken by a decrement-and-skip that skips
   localparam int SKIP_CYCLES = 2;

   typedef enum logic [2:0] {
      CDBA_OP_NONE          = 3'b000,
      CDBA_OP_COMPARE       = 3'b001,
      CDBA_OP_DEC           = 3'b010,
      CDBA_OP_DEC_SKIP      = 3'b011,
      CDBA_OP_BCD_ADJUST    = 3'b100
   } cdba_op_t;

   typedef enum logic [0:0] {
      CDBA_ST_RUN  = 1'b0,
      CDBA_ST_SKIP = 1'b1
   } cdba_state_t;

   // One issued instruction with its operands
   typedef struct packed {
      cdba_op_t            op;
      logic                dest;
      logic [ADDR_W-1:0]   file_addr;
      logic [DATA_W-1:0]   file_val;
      logic [DATA_W-1:0]   working_val;
      logic                carry_in;
      logic                half_carry_in;
   } cdba_req_t;

   // Write-back to working register, file and flags
   typedef struct packed {
      logic                working_we;
      logic [DATA_W-1:0]   working_data;
      logic                file_we;
      logic [ADDR_W-1:0]   file_addr;
      logic [DATA_W-1:0]   file_data;
      logic                zero_we;
      logic                zero_val;
      logic                carry_we;
      logic                carry_val;
   } cdba_wb_t;

   localparam cdba_wb_t WB_RST = '{
      working_we:   1'b0,
      working_data: DATA_RST,
      file_we:      1'b0,
      file_addr:    ADDR_RST,
      file_data:    DATA_RST,
      zero_we:      1'b0,
      zero_val:     1'b0,
      carry_we:     1'b0,
      carry_val:    1'b0
   };

endpackage

// ---- core/cdba_bcd_adjust.sv ----
// Combinational packed-decimal correction of the working register
`timescale 1ns/1ps
module cdba_bcd_adjust (
   input  wire logic [cdba_pkg::DATA_W-1:0] bin_val,
   input  wire logic                        carry_in,
   input  wire logic                        half_carry_in,
   output logic      [cdba_pkg::DATA_W-1:0] bcd_val,
   output logic                             carry_out
);

   wire logic       lo_fix;
   wire logic [4:0] lo_sum;
   wire logic [3:0] hi_mid;
   wire logic       hi_fix;
   wire logic [4:0] hi_sum;

   // Low nibble first; its carry ripples into the high one
   assign lo_fix = (bin_val[3:0] > cdba_pkg::BCD_NIBBLE_MAX)
                   | half_carry_in;
   assign lo_sum = {1'b0, bin_val[3:0]}
                   + (lo_fix ? {1'b0, cdba_pkg::BCD_NIBBLE_FIX} : 5'h00);
   assign hi_mid = bin_val[7:4] + {3'h0, lo_sum[4]};
   // A ripple that wraps the high nibble counts as decimal overflow
   assign hi_fix = (hi_mid > cdba_pkg::BCD_NIBBLE_MAX) | carry_in
                   | (lo_sum[4] & (bin_val[7:4] == 4'hf));
   assign hi_sum = {1'b0, hi_mid}
                   + (hi_fix ? {1'b0, cdba_pkg::BCD_NIBBLE_FIX} : 5'h00);

   assign bcd_val   = {hi_sum[3:0], lo_sum[3:0]};
   assign carry_out = hi_fix;

endmodule // cdba_bcd_adjust

// ---- dv/cdba_unit_properties.sv ----
// Port assertions for the compare, decrement and BCD adjust unit
`timescale 1ns/1ps
module cdba_unit_properties (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                issue_valid,
   input wire cdba_pkg::cdba_req_t issue,
   input wire cdba_pkg::cdba_wb_t  wb_q,
   input wire logic                squash_q,
   input wire logic                nop_q
);
   logic       pend_q;
   wire        skip_w = squash_q || pend_q;
   wire        take_w = issue_valid && !skip_w;
   wire  [2:0] op_w   = issue.op;
   wire  [7:0] fv_w   = issue.file_val;
   wire  [3:0] en_w   = {wb_q.working_we, wb_q.file_we, wb_q.zero_we,
                         wb_q.carry_we};
   // Skip stays pending until an issue arrives to be dropped
   always_ff @(posedge clk) begin
      if (rst)
         pend_q <= 1'b0;
      else
         pend_q <= skip_w && !issue_valid;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_cmp_flags: assert property (
      take_w && op_w == 3'h1 |=> en_w == 4'h3
      && wb_q.carry_val == ($past(fv_w) >= $past(issue.working_val))
      && wb_q.zero_val == ($past(fv_w) == $past(issue.working_val)))
      else $error("compare flags");
   chk_dec_route: assert property (
      take_w && op_w[2:1] == 2'h1 |=> !wb_q.carry_we && wb_q.zero_we
      && wb_q.file_we == $past(issue.dest) && wb_q.working_we != wb_q.file_we
      && wb_q.zero_val == ($past(fv_w) == 8'h01))
      else $error("decrement route");
   chk_dec_value: assert property (
      take_w && op_w[2:1] == 2'h1 |=> $past(fv_w) - 8'h01
      == (wb_q.file_we ? wb_q.file_data : wb_q.working_data))
      else $error("decrement value");
   chk_skip_zero: assert property (
      take_w |=> squash_q == ($past(op_w) == 3'h3 && $past(fv_w) == 8'h01))
      else $error("skip decision");
   chk_skip_nop: assert property (
      skip_w && issue_valid |=> nop_q && en_w == 4'h0 && !squash_q)
      else $error("squashed issue kept");
   chk_bcd_flags: assert property (
      take_w && op_w == 3'h4 |=> en_w == 4'h9
      && (wb_q.carry_val || !$past(issue.carry_in)))
      else $error("decimal adjust");
   chk_idle_quiet: assert property (
      !issue_valid || (take_w && (op_w == 3'h0 || op_w > 3'h4))
      |=> en_w == 4'h0 && !squash_q)
      else $error("spurious write-back");
endmodule // cdba_unit_properties

bind cdba_unit cdba_unit_properties u_props (.clk(clk), .rst(rst),
   .issue_valid(issue_valid), .issue(issue), .wb_q(wb_q),
   .squash_q(squash_q), .nop_q(nop_q));

// ---- dv/testbench.sv ----
// Directed bench for the compare, decrement and BCD adjust unit
`timescale 1ns/1ps
module testbench;
   logic                clk;
   logic                rst;
   logic                issue_valid;
   cdba_pkg::cdba_req_t issue;
   cdba_pkg::cdba_wb_t  wb_q;
   logic                squash_q;
   logic                nop_q;
   int                  errors;
   int                  checks;
   wire  [7:0]          en_w = {3'h0, nop_q, wb_q.working_we, wb_q.file_we,
                                wb_q.zero_we, wb_q.carry_we};
   wire  [7:0]          fl_w = {6'h00, wb_q.zero_val, wb_q.carry_val};

   cdba_unit dut (.clk(clk), .rst(rst), .issue_valid(issue_valid),
      .issue(issue), .wb_q(wb_q), .squash_q(squash_q), .nop_q(nop_q));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Valid stays high, so calls in a row issue back to back
   task automatic send(input logic [2:0] op, input logic d,
                       input logic [7:0] f, input logic [7:0] w,
                       input logic c, input logic h);
      issue = '{cdba_pkg::cdba_op_t'(op), d, 6'h2A, f, w, c, h};
      issue_valid = 1'b1;
      @(posedge clk);
      #1;
   endtask

   // One cycle with nothing issued
   task automatic idle;
      issue_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic t_cmp;
      send(3'h1, 1'b1, 8'h34, 8'h12, 1'b0, 1'b0);
      chk(en_w, 8'h03);
      chk(fl_w, 8'h01);
      send(3'h1, 1'b0, 8'h12, 8'h12, 1'b0, 1'b0);
      chk(fl_w, 8'h03);
      send(3'h1, 1'b0, 8'h12, 8'h34, 1'b1, 1'b0);
      chk(fl_w, 8'h00);
   endtask

   task automatic t_dec;
      send(3'h2, 1'b0, 8'h00, 8'h55, 1'b1, 1'b1);
      chk(en_w, 8'h0A);
      chk(wb_q.working_data, 8'hFF);
      chk(fl_w & 8'h02, 8'h00);
      send(3'h2, 1'b1, 8'h01, 8'h55, 1'b0, 1'b0);
      chk(en_w, 8'h06);
      chk(wb_q.file_data, 8'h00);
      chk(8'(wb_q.file_addr), 8'h2A);
      chk(fl_w & 8'h02, 8'h02);
      send(3'h0, 1'b1, 8'h01, 8'h55, 1'b0, 1'b0);
      chk(en_w, 8'h00);
      // Unused op codes must write nothing
      send(3'h7, 1'b1, 8'h01, 8'h55, 1'b1, 1'b1);
      chk(en_w | 8'(squash_q), 8'h00);
   endtask

   task automatic t_skip;
      send(3'h3, 1'b0, 8'h05, 8'h00, 1'b0, 1'b0);
      chk(wb_q.working_data, 8'h04);
      chk(8'(squash_q), 8'h00);
      send(3'h3, 1'b1, 8'h01, 8'h00, 1'b0, 1'b0);
      chk(en_w, 8'h06);
      chk(8'(squash_q), 8'h01);
      send(3'h2, 1'b1, 8'h09, 8'h00, 1'b0, 1'b0);
      chk(en_w, 8'h10);
      send(3'h2, 1'b1, 8'h09, 8'h00, 1'b0, 1'b0);
      chk(en_w, 8'h06);
      chk(wb_q.file_data, 8'h08);
      // Prefetch may arrive late; the skip waits for it
      send(3'h3, 1'b0, 8'h01, 8'h00, 1'b0, 1'b0);
      chk(en_w, 8'h0A);
      idle();
      chk(en_w | 8'(squash_q), 8'h00);
      send(3'h1, 1'b0, 8'h12, 8'h12, 1'b0, 1'b0);
      chk(en_w, 8'h10);
   endtask

   // Entry: input, result, carry and half carry in, carry out
   task automatic t_bcd;
      logic [23:0] tv [5] = '{24'h4D_5300, 24'h9A_0001, 24'h12_1810,
                              24'h30_9021, 24'h99_9900};
      foreach (tv[i]) begin
         send(3'h4, 1'b0, 8'h00, tv[i][23:16],
              tv[i][5], tv[i][4]);
         chk(en_w, 8'h09);
         chk(wb_q.working_data, tv[i][15:8]);
         chk(fl_w & 8'h01, 8'(tv[i][0]));
      end
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      errors = 0;
      checks = 0;
      rst = 1'b1;
      issue_valid = 1'b0;
      issue = '0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk);
      #1;
      t_cmp();
      t_dec();
      t_skip();
      t_bcd();
      tally_and_finish();
   end
endmodule // testbench
